// ===== logic/ufs_pkg.sv
// shared constants and types of the serial frame and clock-edge engine
// assumes a single 125 MHz peripheral clock for every user of this package
package ufs_pkg;

	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int BAUD_W = 12;
	localparam int CHAR_W = 9;
	localparam int CLOCK_PERIOD_NS = 8;
	localparam logic [4:0] OVERSAMPLE_NORMAL = 5'h10;
	localparam logic [4:0] OVERSAMPLE_DOUBLE = 5'h08;
	localparam logic [3:0] SPI_FRAME_BITS = 4'h8;
	localparam logic [3:0] VAR_CHUNK_BITS = 4'h8;
	localparam logic [3:0] CHAR_BITS_MIN = 4'h5;
	localparam logic [3:0] CHAR_BITS_MAX = 4'h9;
	localparam logic [2:0] CHAR_CODE_MAX = 3'h4;

	// ----------------------------------------------------------------
	// line levels and reset values
	// ----------------------------------------------------------------
	localparam logic TXD_IDLE = 1'b1;
	localparam logic START_LEVEL = 1'b0;
	localparam logic STOP_LEVEL = 1'b1;
	localparam logic [BAUD_W-1:0] BAUD_CNT_RESET = 12'h000;
	localparam logic [4:0] PRESC_RESET = 5'h00;
	localparam logic [3:0] BIT_CNT_RESET = 4'h0;
	localparam logic [CHAR_W-1:0] WORD_RESET = 9'h000;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ASYNC = 2'b00,
		MODE_SYNC_MASTER = 2'b01,
		MODE_SYNC_SLAVE = 2'b10,
		MODE_SPI_MASTER = 2'b11
	} ufs_mode_t;

	typedef enum logic [1:0] {
		PARITY_NONE = 2'b00,
		PARITY_RSVD = 2'b01,
		PARITY_EVEN = 2'b10,
		PARITY_ODD = 2'b11
	} ufs_parity_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PARITY = 3'b011,
		ST_STOP1 = 3'b100,
		ST_STOP2 = 3'b101
	} ufs_state_t;

endpackage

// ===== logic/ufs_baud.sv
// baud period counter: one-cycle tick every (period + 1) clocks while run
// assumes period is held steady while run is high
`timescale 1ns/1ps
module ufs_baud
	import ufs_pkg::*;
#(
	parameter int WIDTH = BAUD_W
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic [WIDTH-1:0] i_period,
	output logic o_tick
);

	logic [WIDTH-1:0] cnt;
	logic [WIDTH-1:0] next_cnt;
	logic tick;
	logic next_tick;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	// restarting from zero on every run keeps bit timing aligned to load
	always_comb begin
		next_cnt = cnt;
		next_tick = 1'b0;
		if (!i_run) begin
			next_cnt = '0;
		end else if (cnt == i_period) begin
			next_cnt = '0;
			next_tick = 1'b1;
		end else begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end

	assign o_tick = tick;

endmodule

// ===== logic/ufs_core.sv
// serial transmit frame engine with sync, slave and spi master clocking
// assumes config inputs stay steady while a frame is on the line
// Contract
// - no inversion: change rising, sample falling
// - inversion: change on falling clock edge
// - spi master clock only from baud generator
// - phase zero samples leading, phase one trailing
// - shift and latch on opposite edges
// - 5-9 data bits, parity, 1-2 stops
// - variable length ended by external counter
// - start, data lsb first, parity, stops
// - next start may follow stop directly
// - start low, stops high, idle high
// - even/odd parity from data one count
// - no parity with variable length
// - spi: 8 bits msb/lsb, variable lsb
// - spi frames back to back or idle
// - sync master drives clock pin out
// - enabled transmitter owns transmit pin; code drives it only with one-wire or port output set
// - one-wire pin forced output when enabled
// - clock pin out master, in slave
// - period 0-4095, rate clk/(2(p+1))
`timescale 1ns/1ps
module ufs_core
	import ufs_pkg::*;
(
	input wire logic I_CLOCK,
	input wire logic I_RESETN,
	input wire logic [1:0] I_MODE,
	input wire logic I_CLOCK_PIN_INVERSION,
	input wire logic I_CLOCK_PHASE_SELECT,
	input wire logic I_MSB_FIRST,
	input wire logic [2:0] I_CHAR_SIZE,
	input wire logic [1:0] I_PARITY_MODE,
	input wire logic I_TWO_STOP_BITS,
	input wire logic I_VAR_LENGTH,
	input wire logic I_ONE_WIRE,
	input wire logic I_TX_ENABLE,
	input wire logic I_RX_ENABLE,
	input wire logic I_TX_PORT_OUTPUT,
	input wire logic [BAUD_W-1:0] I_BAUD_PERIOD_SETTING,
	input wire logic I_DOUBLE_SPEED_SELECT,
	input wire logic [CHAR_W-1:0] I_TX_DATA,
	input wire logic I_TX_VALID,
	output logic O_TX_READY,
	output logic O_TX_BUSY,
	input wire logic I_EXTERNAL_BIT_COUNTER_MATCH,
	output logic O_EXTERNAL_BIT_COUNTER_RESTART,
	output logic O_EXTERNAL_BIT_COUNTER_DECREMENT,
	input wire logic I_RXD,
	input wire logic I_TXD_PIN,
	output logic O_TXD,
	output logic O_TXD_OE,
	input wire logic I_TRANSFER_CLOCK_PIN,
	output logic O_TRANSFER_CLOCK_PIN,
	output logic O_TRANSFER_CLOCK_PIN_OE,
	output logic [CHAR_W-1:0] O_RX_DATA,
	output logic O_RX_VALID
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] char_bits(input logic [2:0] code);
		char_bits = (code > CHAR_CODE_MAX) ? CHAR_BITS_MAX :
			CHAR_BITS_MIN + {1'b0, code};
	endfunction

	function automatic logic tx_bit(input ufs_state_t st,
		input logic [CHAR_W-1:0] sh, input logic p, input logic msb);
		case (st)
			ST_START: tx_bit = START_LEVEL;
			ST_DATA: tx_bit = msb ? sh[7] : sh[0];
			ST_PARITY: tx_bit = p;
			default: tx_bit = STOP_LEVEL;
		endcase
	endfunction

	// odd count of ones gives 1 for even parity, 0 for odd parity
	function automatic logic parity_of(input logic [CHAR_W-1:0] d,
		input logic [3:0] n, input logic odd);
		logic acc;
		acc = odd;
		for (int i = 0; i < CHAR_W; i++) begin
			if (4'(i) < n) begin
				acc = acc ^ d[i];
			end
		end
		parity_of = acc;
	endfunction

	// ----------------------------------------------------------------
	// state and events
	// ----------------------------------------------------------------
	ufs_state_t state, next_state;
	logic [CHAR_W-1:0] shift, next_shift, buf_data, next_buf_data;
	logic [CHAR_W-1:0] rx_shift, next_rx_shift, rx_data, next_rx_data;
	logic buf_full, next_buf_full, par, next_par;
	logic raw_clk, next_raw_clk, xck_prev, next_xck_prev;
	logic txd, next_txd, txd_oe, next_txd_oe, transfer_clock_pin, next_xck;
	logic xck_oe, next_xck_oe, tx_ready, next_tx_ready;
	logic busy, next_busy, rx_valid, next_rx_valid;
	logic restart, next_restart, dec, next_dec;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [4:0] presc, next_presc;

	ufs_mode_t mode;
	ufs_parity_t pmode;
	logic is_master, is_spi, is_async, phase0, lead_change, active;
	logic pin_raw, lead_ev, trail_ev, step, sample_ev, baud_tick;
	logic msb_sel, rx_in;
	logic [4:0] oversample;
	logic [3:0] frame_bits, rx_idx;

	assign mode = ufs_mode_t'(I_MODE);
	assign pmode = ufs_parity_t'(I_PARITY_MODE);
	assign is_master = (mode == MODE_SYNC_MASTER) || (mode == MODE_SPI_MASTER);
	assign is_spi = (mode == MODE_SPI_MASTER);
	assign is_async = (mode == MODE_ASYNC);
	assign phase0 = is_spi && !I_CLOCK_PHASE_SELECT;
	assign lead_change = !is_async && !phase0;
	assign active = (state != ST_IDLE);
	// inversion folded in: slave leading edge is always a rise of pin_raw
	assign pin_raw = I_TRANSFER_CLOCK_PIN ^ I_CLOCK_PIN_INVERSION;
	assign lead_ev = active && (is_master ? (baud_tick && !raw_clk) :
		(mode == MODE_SYNC_SLAVE && pin_raw && !xck_prev));
	assign trail_ev = active && (is_master ? (baud_tick && raw_clk) :
		(mode == MODE_SYNC_SLAVE && !pin_raw && xck_prev));
	assign oversample = I_DOUBLE_SPEED_SELECT ? OVERSAMPLE_DOUBLE :
		OVERSAMPLE_NORMAL;
	assign step = is_async ?
		(active && baud_tick && presc == oversample - 5'h01) : trail_ev;
	// sample on the edge opposite the data change
	assign sample_ev = I_RX_ENABLE && state == ST_DATA &&
		(phase0 ? lead_ev : trail_ev);
	assign msb_sel = is_spi && I_MSB_FIRST && !I_VAR_LENGTH;
	assign frame_bits = is_spi ? SPI_FRAME_BITS : char_bits(I_CHAR_SIZE);
	assign rx_idx = msb_sel ? (4'h7 - bit_cnt) : bit_cnt;
	assign rx_in = I_ONE_WIRE ? I_TXD_PIN : I_RXD;

	// master clock comes only from the internal divider
	ufs_baud #(
		.WIDTH(BAUD_W)
	) u_baud (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RESETN),
		.i_run(active),
		.i_period(I_BAUD_PERIOD_SETTING),
		.o_tick(baud_tick)
	);

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	always_comb begin
		logic load, data_done, frame_end, emit;
		load = 1'b0;
		data_done = 1'b0;
		frame_end = 1'b0;
		emit = 1'b0;
		next_state = state;
		next_shift = shift;
		next_buf_data = buf_data;
		next_buf_full = buf_full;
		next_par = par;
		next_bit_cnt = bit_cnt;
		next_rx_shift = rx_shift;
		next_rx_data = rx_data;
		next_rx_valid = 1'b0;
		next_restart = 1'b0;
		next_dec = 1'b0;
		next_presc = presc;
		next_xck_prev = pin_raw;
		next_raw_clk = raw_clk;
		if (I_TX_VALID && tx_ready) begin
			next_buf_full = 1'b1;
			next_buf_data = I_TX_DATA;
		end
		if (!is_master) begin
			next_raw_clk = 1'b0;
		end else if (active && baud_tick) begin
			next_raw_clk = !raw_clk;
		end
		if (!active) begin
			next_presc = PRESC_RESET;
		end else if (is_async && baud_tick) begin
			next_presc = (presc == oversample - 5'h01) ? PRESC_RESET :
				presc + 5'h01;
		end
		if (sample_ev) begin
			next_rx_shift[rx_idx] = rx_in;
		end
		if (state == ST_IDLE) begin
			load = buf_full && I_TX_ENABLE;
		end else if (step) begin
			case (state)
				ST_START: begin
					next_state = ST_DATA;
					next_bit_cnt = BIT_CNT_RESET;
				end
				ST_DATA: begin
					next_bit_cnt = bit_cnt + 4'h1;
					next_shift = msb_sel ? {shift[7:0], 1'b0} : shift >> 1;
					if (I_VAR_LENGTH) begin
						next_dec = 1'b1;
					end
					if (I_VAR_LENGTH && I_EXTERNAL_BIT_COUNTER_MATCH) begin
						data_done = 1'b1;
					end else if (I_VAR_LENGTH &&
						bit_cnt == VAR_CHUNK_BITS - 4'h1) begin
						emit = 1'b1;
						next_bit_cnt = BIT_CNT_RESET;
						if (buf_full) begin
							next_shift = buf_data;
							next_buf_full = 1'b0;
						end else begin
							// no data and no match: frame is abandoned
							next_state = ST_IDLE;
						end
					end else if (!I_VAR_LENGTH &&
						bit_cnt == frame_bits - 4'h1) begin
						data_done = 1'b1;
					end
					if (data_done) begin
						emit = 1'b1;
						if (is_spi) begin
							frame_end = 1'b1;
						end else if (!I_VAR_LENGTH && (pmode == PARITY_EVEN ||
							pmode == PARITY_ODD)) begin
							next_state = ST_PARITY;
						end else begin
							next_state = ST_STOP1;
						end
					end
				end
				ST_PARITY: next_state = ST_STOP1;
				ST_STOP1: begin
					if (I_TWO_STOP_BITS) begin
						next_state = ST_STOP2;
					end else begin
						frame_end = 1'b1;
					end
				end
				default: frame_end = 1'b1;
			endcase
		end
		if (frame_end) begin
			load = buf_full && I_TX_ENABLE;
			if (!load) begin
				next_state = ST_IDLE;
			end
		end
		if (emit && I_RX_ENABLE) begin
			next_rx_data = next_rx_shift;
			next_rx_valid = 1'b1;
			next_rx_shift = WORD_RESET;
		end
		if (load) begin
			next_shift = buf_data;
			next_buf_full = 1'b0;
			next_par = parity_of(buf_data, frame_bits,
				pmode == PARITY_ODD);
			next_state = is_spi ? ST_DATA : ST_START;
			next_bit_cnt = BIT_CNT_RESET;
			next_restart = I_VAR_LENGTH;
		end
		if (next_state == ST_IDLE) begin
			next_txd = TXD_IDLE;
		end else if (!lead_change) begin
			next_txd = tx_bit(next_state, next_shift, next_par, msb_sel);
		end else if (lead_ev) begin
			// change on leading edge: rising, or falling when inverted
			next_txd = tx_bit(state, shift, par, msb_sel);
		end else begin
			next_txd = txd;
		end
		next_txd_oe = (I_TX_ENABLE || active) &&
			(I_ONE_WIRE || I_TX_PORT_OUTPUT);
		next_xck_oe = is_master;
		next_xck = is_master && (next_raw_clk ^ I_CLOCK_PIN_INVERSION);
		next_tx_ready = !next_buf_full;
		next_busy = (next_state != ST_IDLE) || next_buf_full;
	end

	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state <= ST_IDLE;
			shift <= WORD_RESET;
			buf_data <= WORD_RESET;
			buf_full <= 1'b0;
			par <= 1'b0;
			bit_cnt <= BIT_CNT_RESET;
			rx_shift <= WORD_RESET;
			rx_data <= WORD_RESET;
			rx_valid <= 1'b0;
			restart <= 1'b0;
			dec <= 1'b0;
			presc <= PRESC_RESET;
			xck_prev <= 1'b0;
			raw_clk <= 1'b0;
			txd <= TXD_IDLE;
			txd_oe <= 1'b0;
			transfer_clock_pin <= 1'b0;
			xck_oe <= 1'b0;
			tx_ready <= 1'b0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			shift <= next_shift;
			buf_data <= next_buf_data;
			buf_full <= next_buf_full;
			par <= next_par;
			bit_cnt <= next_bit_cnt;
			rx_shift <= next_rx_shift;
			rx_data <= next_rx_data;
			rx_valid <= next_rx_valid;
			restart <= next_restart;
			dec <= next_dec;
			presc <= next_presc;
			xck_prev <= next_xck_prev;
			raw_clk <= next_raw_clk;
			txd <= next_txd;
			txd_oe <= next_txd_oe;
			transfer_clock_pin <= next_xck;
			xck_oe <= next_xck_oe;
			tx_ready <= next_tx_ready;
			busy <= next_busy;
		end
	end

	assign O_TXD = txd;
	assign O_TXD_OE = txd_oe;
	assign O_TRANSFER_CLOCK_PIN = transfer_clock_pin;
	assign O_TRANSFER_CLOCK_PIN_OE = xck_oe;
	assign O_TX_READY = tx_ready;
	assign O_TX_BUSY = busy;
	assign O_RX_DATA = rx_data;
	assign O_RX_VALID = rx_valid;
	assign O_EXTERNAL_BIT_COUNTER_RESTART = restart;
	assign O_EXTERNAL_BIT_COUNTER_DECREMENT = dec;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RESETN);

	a_idle_line_high: assert property (
		state == ST_IDLE |-> O_TXD == TXD_IDLE)
		else $error("line not high while idle");
	a_start_bit_low: assert property (
		is_async && state == ST_START |-> O_TXD == START_LEVEL)
		else $error("start bit not low");
	a_stop_bits_high: assert property (
		is_async && (state == ST_STOP1 || state == ST_STOP2) |-> O_TXD)
		else $error("stop bit not high");
	a_parity_value: assert property (
		is_async && state == ST_START |->
		par == parity_of(shift, frame_bits, pmode == PARITY_ODD))
		else $error("parity bit wrong");
	a_parity_on_line: assert property (
		is_async && state == ST_PARITY |-> O_TXD == par)
		else $error("parity bit not on line");
	a_no_var_parity: assert property (
		I_VAR_LENGTH && $past(I_VAR_LENGTH) |-> state != ST_PARITY)
		else $error("parity used with variable length");
	a_edges_apart: assert property (
		!(lead_ev && trail_ev))
		else $error("leading and trailing edge together");
	a_change_on_lead: assert property (
		lead_change && state != ST_IDLE && $changed(O_TXD) |->
		$past(lead_ev))
		else $error("data changed off the leading edge");
	a_master_clock_src: assert property (
		is_master && $past(is_master) && $changed(raw_clk) |->
		$past(baud_tick))
		else $error("master clock moved without baud tick");
	a_clock_pin_dir: assert property (
		mode == MODE_SYNC_MASTER ##1 mode == MODE_SYNC_MASTER |->
		O_TRANSFER_CLOCK_PIN_OE ##0 (mode != MODE_SYNC_SLAVE))
		else $error("master does not drive clock pin");
	a_one_wire_out: assert property (
		I_ONE_WIRE && I_TX_ENABLE |=> O_TXD_OE)
		else $error("one-wire pin not driven");
	a_spi_no_sync_bits: assert property (
		is_spi && $past(is_spi) |-> state inside {ST_IDLE, ST_DATA})
		else $error("spi frame carries start or stop");

	c_async_back_to_back: cover property (
		is_async && state == ST_STOP1 ##1 state == ST_START);
	c_spi_frame_done: cover property (
		is_spi && state == ST_DATA ##1 O_RX_VALID);
	c_var_length_end: cover property (
		I_VAR_LENGTH && state == ST_DATA && step &&
		I_EXTERNAL_BIT_COUNTER_MATCH);
	c_slave_frame: cover property (
		mode == MODE_SYNC_SLAVE && state == ST_STOP1);

endmodule

// ===== verif/ufs_far_end.sv
// far-end model: async line receiver, spi slave and sync partner
// assumes arm() is called at a falling clock edge with the line idle
`timescale 1ns/1ps
module ufs_far_end (
	input wire logic i_clk,
	input wire logic i_txd,
	input wire logic i_sclk,
	output logic o_rxd
);
	logic armed = 1'b0;
	logic sync, lead, inv, busy, sclk_d, txd_d;
	logic [7:0] reply;
	logic [15:0] got;
	int n, bitlen, cnt, idx, frames;
	int tgl = 0;
	int half = 0;

	initial o_rxd = 1'b0;

	task automatic arm(input logic s, l, v, input int nb, bl,
		input logic [7:0] r);
		sync = s;
		lead = l;
		inv = v;
		n = nb;
		bitlen = bl;
		reply = r;
		idx = 0;
		busy = 1'b0;
		frames = 0;
		got = 16'h0000;
		o_rxd = r[0];
		armed = 1'b1;
	endtask

	always @(posedge i_clk) begin
		sclk_d <= i_sclk;
		// line level as it stood at the clock edge itself
		txd_d <= i_txd;
		tgl <= tgl + 1;
		if (!armed) begin
			// released line: never leave a stale level to be sampled
			o_rxd <= ~o_rxd;
		end else if (sync) begin
			if (i_sclk != sclk_d) begin
				half <= tgl;
				tgl <= 1;
				// sample edge opposite the change edge
				if ((i_sclk ^ inv) == lead) begin
					got[idx] <= txd_d;
					o_rxd <= reply[(idx + 1) % 8];
					idx <= idx + 1;
					if (idx + 1 == n) armed <= 1'b0;
				end
			end
		end else if (!busy) begin
			if (i_txd == 1'b0) begin
				busy <= 1'b1;
				cnt <= bitlen / 2;
			end
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else begin
			got[idx] <= i_txd;
			idx <= idx + 1;
			cnt <= bitlen;
			if (idx + 1 == n) begin
				busy <= 1'b0;
				frames <= frames + 1;
				idx <= 0;
			end
		end
	end
endmodule

// ===== verif/usart_frame_and_sync_spi_clocking_test.sv
// self-checking bench of the serial frame and clock-edge engine
// assumes ufs_core with a 125 MHz clock and the far-end model beside it
`timescale 1ns/1ps
module usart_frame_and_sync_spi_clocking_test
	import ufs_pkg::*;
;
	localparam int LIMIT = 20000;
	localparam logic [1:0] PARS [5] = '{PARITY_NONE, PARITY_EVEN,
		PARITY_ODD, PARITY_RSVD, PARITY_EVEN};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [1:0] par = 2'h0;
	logic inv = 1'b0, ph = 1'b0, msb = 1'b0, two = 1'b0, vl = 1'b0;
	logic ow = 1'b0, tx_en = 1'b1, port_out = 1'b1, dbl = 1'b0;
	logic valid = 1'b0;
	logic xin = 1'b0;
	logic [15:0] got_s;
	logic [2:0] cs = 3'h3;
	logic [11:0] per = 12'h000;
	logic [8:0] data = 9'h000;
	logic [8:0] ctr = 9'h000;
	logic [8:0] rx_data, rxw;
	logic ready, busy, restart, dec, txd, txd_oe, sclk, sclk_oe;
	logic rx_valid, rxd;
	logic [15:0] e;
	int fails = 0, compares = 0, cyc = 0, n_dec = 0, n;

	initial begin
		forever #4 clk = ~clk;
	end

	ufs_core dut (.I_CLOCK(clk), .I_RESETN(rst_n), .I_MODE(mode),
		.I_CLOCK_PIN_INVERSION(inv), .I_CLOCK_PHASE_SELECT(ph),
		.I_MSB_FIRST(msb), .I_CHAR_SIZE(cs), .I_PARITY_MODE(par),
		.I_TWO_STOP_BITS(two), .I_VAR_LENGTH(vl), .I_ONE_WIRE(ow),
		.I_TX_ENABLE(tx_en), .I_RX_ENABLE(1'b1),
		.I_TX_PORT_OUTPUT(port_out), .I_BAUD_PERIOD_SETTING(per),
		.I_DOUBLE_SPEED_SELECT(dbl), .I_TX_DATA(data),
		.I_TX_VALID(valid), .O_TX_READY(ready), .O_TX_BUSY(busy),
		.I_EXTERNAL_BIT_COUNTER_MATCH(ctr == 9'h000),
		.O_EXTERNAL_BIT_COUNTER_RESTART(restart),
		.O_EXTERNAL_BIT_COUNTER_DECREMENT(dec), .I_RXD(rxd),
		.I_TXD_PIN(txd), .O_TXD(txd), .O_TXD_OE(txd_oe),
		.I_TRANSFER_CLOCK_PIN(xin), .O_TRANSFER_CLOCK_PIN(sclk),
		.O_TRANSFER_CLOCK_PIN_OE(sclk_oe), .O_RX_DATA(rx_data),
		.O_RX_VALID(rx_valid));

	ufs_far_end far (.i_clk(clk), .i_txd(txd), .i_sclk(sclk),
		.o_rxd(rxd));

	// ------------------------------------------------------------
	// external bit counter, receive capture, watchdog
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (restart === 1'b1) begin
			ctr <= 9'h003;
		end else if (dec === 1'b1) begin
			ctr <= ctr - 9'h001;
			n_dec <= n_dec + 1;
		end
		if (rx_valid === 1'b1) rxw <= rx_data;
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails = fails + 1;
			$display("ERROR watchdog expired");
			summarize();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// only called with the line idle
	task automatic cfg(input logic [1:0] m, input logic v, h, b,
		input logic [2:0] c, input logic [1:0] pm,
		input logic t, l, d, input logic [11:0] p);
		@(posedge clk);
		mode <= m;
		inv <= v;
		ph <= h;
		msb <= b;
		cs <= c;
		par <= pm;
		two <= t;
		vl <= l;
		dbl <= d;
		per <= p;
		repeat (2) @(posedge clk);
	endtask

	task automatic send(input logic [8:0] d);
		@(posedge clk);
		valid <= 1'b1;
		data <= d;
		do @(posedge clk); while (ready !== 1'b1);
		valid <= 1'b0;
	endtask

	task automatic wait_idle;
		repeat (3) @(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask

	// line bits of one frame, start bit at index 0
	function automatic logic [15:0] frame(input logic [8:0] d,
		input int nd, input logic [1:0] pm, input logic t,
		output int nb);
		logic p;
		int j;
		frame = 16'h0000;
		p = 1'b0;
		j = 1;
		for (int i = 0; i < nd; i++) begin
			frame[j] = d[i];
			p ^= d[i];
			j++;
		end
		if (pm[1]) begin
			frame[j] = p ^ pm[0];
			j++;
		end
		frame[j] = STOP_LEVEL;
		frame[j + 1] = t;
		nb = j + 1 + int'(t);
	endfunction

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		chk("line in reset", txd, 1);
		chk("ready in reset", ready, 0);
		rst_n <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			cfg(MODE_ASYNC, 0, 0, 0, c[2:0], PARS[c], c[0], 0, c == 4, 0);
			e = frame(9'h1a5 ^ {6'h00, c[2:0]}, 5 + c, PARS[c], c[0], n);
			@(negedge clk) far.arm(0, 0, 0, n, (c == 4) ? 8 : 16, 8'h00);
			send(9'h1a5 ^ {6'h00, c[2:0]});
			wait_idle();
			chk("async frame", far.got, e);
			chk("idle line", txd, 1);
		end
		$display("test async formats done");
		cfg(MODE_ASYNC, 0, 0, 0, 3'h3, PARITY_NONE, 0, 0, 0, 0);
		e = frame(9'h0c3, 8, PARITY_NONE, 0, n);
		@(negedge clk) far.arm(0, 0, 0, n, 16, 8'h00);
		send(9'h03c);
		send(9'h0c3);
		wait_idle();
		chk("frame count", far.frames[15:0], 2);
		chk("second frame", far.got, e);
		$display("test back to back done");
		cfg(MODE_ASYNC, 0, 0, 0, 3'h3, PARITY_EVEN, 0, 1, 0, 0);
		// match is seen at the step after the third decrement lands
		e = frame(9'h005, 4, PARITY_NONE, 0, n);
		@(negedge clk) far.arm(0, 0, 0, n, 16, 8'h00);
		n_dec = 0;
		send(9'h005);
		wait_idle();
		chk("variable frame", far.got, e);
		chk("bit steps", n_dec[15:0], 4);
		$display("test variable length done");
		for (int c = 0; c < 8; c++) begin
			cfg(MODE_SPI_MASTER, c[0], c[1], c[2], 3'h3, PARITY_NONE,
				0, 0, 0, 12'h003);
			chk("clock idle level", sclk, c[0]);
			for (int i = 0; i < 8; i++) begin
				e[i] = c[2] ? 8'h1d >> (7 - i) : 8'h1d >> i;
				e[8 + i] = c[2] ? 8'hb4 >> (7 - i) : 8'hb4 >> i;
			end
			@(negedge clk) far.arm(1, !c[1], c[0], 16, 0, 8'h5a);
			rxw = 9'h000;
			send(9'h01d);
			send(9'h0b4);
			wait_idle();
			chk("spi bits", far.got, e);
			chk("spi half period", far.half[15:0], 4);
			chk("spi receive", rxw[7:0], 8'h5a);
			chk("spi idle line", txd, 1);
		end
		$display("test spi modes done");
		for (int v = 0; v < 2; v++) begin
			cfg(MODE_SYNC_MASTER, v[0], 0, 0, 3'h3, PARITY_EVEN,
				0, 0, 0, 12'h003);
			e = frame(9'h0b2, 8, PARITY_EVEN, 0, n);
			@(negedge clk) far.arm(1, 0, v[0], n, 0, 8'h5a);
			send(9'h0b2);
			wait_idle();
			chk("sync frame", far.got, e);
		end
		$display("test sync master done");
		cfg(MODE_SYNC_SLAVE, 0, 0, 0, 3'h3, PARITY_NONE, 0, 0, 0, 0);
		e = frame(9'h0a6, 8, PARITY_NONE, 0, n);
		got_s = 16'h0000;
		send(9'h0a6);
		for (int k = 0; k < n; k++) begin
			repeat (2) @(posedge clk);
			xin <= 1'b1;
			repeat (4) @(posedge clk);
			got_s[k] = txd;
			xin <= 1'b0;
		end
		wait_idle();
		chk("slave frame", got_s, e);
		$display("test sync slave done");
		for (int m = 0; m < 4; m++) begin
			cfg(m[1:0], 0, 0, 0, 3'h3, PARITY_NONE, 0, 0, 0, 0);
			chk("clock pin drive", sclk_oe, m == 1 || m == 3);
		end
		@(posedge clk) ow <= 1'b1;
		port_out <= 1'b0;
		repeat (2) @(posedge clk);
		chk("one wire drive", txd_oe, 1);
		ow <= 1'b0;
		repeat (2) @(posedge clk);
		chk("port input", txd_oe, 0);
		port_out <= 1'b1;
		repeat (2) @(posedge clk);
		chk("port output", txd_oe, 1);
		tx_en <= 1'b0;
		repeat (2) @(posedge clk);
		chk("disabled drive", txd_oe, 0);
		$display("test pin ownership done");
		summarize();
	end
endmodule
